// *** core/qpb_cfg.svh ***
`ifndef QPB_CFG_SVH
`define QPB_CFG_SVH

// --------------------------------------------------------------------
// burst shape
// --------------------------------------------------------------------
`define QPB_BURST 4
`define QPB_LANE_W 9
`define QPB_DATA_W 36
`define QPB_ADDR_W 19
`define QPB_ARR_AW 8

// --------------------------------------------------------------------
// timing in half cycles of the input clock pair; QPB_CAP_LAST is the last beat index
// --------------------------------------------------------------------
`define QPB_LAT_DLL 4'h5
`define QPB_LAT_BYP 4'h2
`define QPB_WR_FIRST 4'h2
`define QPB_WR_LAST 4'h5
`define QPB_WR_COMMIT 4'h6
`define QPB_CMD_GAP 2'h3
`define QPB_CAP_LAST 2'h3

`endif

// *** core/qpb_pkg.sv ***
package qpb_pkg;

    // phase of a double-rate link edge: true clock or complementary clock
    typedef enum logic {
        QPB_PH_K,
        QPB_PH_KN
    } qpb_phase_t;

endpackage : qpb_pkg

// *** core/qpb_if.sv ***
`timescale 1ns/1ps
`include "qpb_cfg.svh"

interface qpb_if #(
    parameter int DATA_W = `QPB_DATA_W,
    parameter int ADDR_W = `QPB_ADDR_W
);
    import qpb_pkg::*;
    localparam int NL = DATA_W / `QPB_LANE_W;

    // double-rate edge clock, one rising edge per k or k# rise
    logic k2x;
    qpb_phase_t k_phase;
    logic rd_sel_n;
    logic wr_sel_n;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [NL-1:0] byte_write_mask_n;
    logic doff_n;
    logic [DATA_W-1:0] rd_data;
    logic echo_timing_out;
    logic echo_timing_out_inv;
    logic output_valid_flag;

    modport dev (
        input k2x, k_phase, rd_sel_n, wr_sel_n, rd_addr, wr_addr, wr_data, byte_write_mask_n, doff_n,
        output rd_data, echo_timing_out, echo_timing_out_inv, output_valid_flag
    );

    modport ctl (
        output k2x, k_phase, rd_sel_n, wr_sel_n, rd_addr, wr_addr, wr_data, byte_write_mask_n, doff_n,
        input rd_data, echo_timing_out, echo_timing_out_inv, output_valid_flag
    );
endinterface : qpb_if

// *** core/qpb_dev.sv ***
// What this block does
// - write only bytes whose mask is low
// - mask sampled with its data beat
// - every access is exactly four beats
// - read starts on low select at k
// - controller reads at most every other cycle
// - free running echo clocks match data
// - first read beat 2.5 cycles later with dll on
// - later beats on alternating following edges
// - idle read select never aborts bursts
// - write starts on low select at k
// - each write moves exactly four beats
// - first write beat one cycle later
// - remaining write beats on alternating edges
// - write buffered, committed in third cycle
// - reads see buffered recent writes
// - masks act per byte per beat
// - high write select starts nothing
// - burst addresses count base plus three
// - valid flag leads data by half cycle
// - read and write ports run concurrently
// - dll off gives one cycle latency
`timescale 1ns/1ps
`include "qpb_cfg.svh"

module qpb_dev #(
    parameter int DATA_W = `QPB_DATA_W,
    parameter int ADDR_W = `QPB_ADDR_W,
    parameter int ARR_AW = `QPB_ARR_AW
) (
    // link
    qpb_if.dev link,
    // reset
    input wire logic rst_b_in
);
    import qpb_pkg::*;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    localparam int NL = DATA_W / `QPB_LANE_W;
    localparam int NRS = 3;
    localparam int DEPTH = 1 << ARR_AW;

    typedef logic [DATA_W-1:0] qpb_word_t;
    typedef logic [ADDR_W-1:0] qpb_addr_t;

    typedef struct packed {
        logic [1:0] doff_sync;
        logic echo;
        logic vld;
        qpb_word_t q;
        logic [NRS-1:0] rs_v;
        logic [NRS-1:0][3:0] rs_cnt;
        logic [NRS-1:0][ADDR_W-1:0] rs_base;
        logic wsel;
        logic [1:0] wb_v;
        logic [1:0][3:0] wb_cnt;
        logic [1:0][ADDR_W-1:0] wb_base;
        logic [1:0][`QPB_BURST-1:0][DATA_W-1:0] wb_d;
        logic [1:0][`QPB_BURST-1:0][NL-1:0] wb_en;
        logic [DEPTH-1:0][DATA_W-1:0] mem;
    } qpb_dev_st_t;

    qpb_dev_st_t st_ff;
    qpb_dev_st_t nxt_st;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic qpb_addr_t qpb_baddr(input qpb_addr_t base, input int beat);
        qpb_baddr = base + ADDR_W'(beat);
    endfunction : qpb_baddr

    function automatic qpb_word_t qpb_merge(input qpb_word_t old_w, input qpb_word_t new_w,
                                            input logic [NL-1:0] en);
        qpb_word_t res;
        res = old_w;
        for (int l = 0; l < NL; l++) begin
            if (en[l]) begin
                res[l*`QPB_LANE_W +: `QPB_LANE_W] = new_w[l*`QPB_LANE_W +: `QPB_LANE_W];
            end
        end
        qpb_merge = res;
    endfunction : qpb_merge

    // array word overlaid by both buffers, newest last
    function automatic qpb_word_t qpb_fetch(input qpb_dev_st_t s, input qpb_addr_t ra);
        qpb_word_t w;
        logic b;
        w = s.mem[ra[ARR_AW-1:0]];
        for (int k = 0; k < 2; k++) begin
            b = (k == 0) ? s.wsel : ~s.wsel;
            if (s.wb_v[b]) begin
                for (int j = 0; j < `QPB_BURST; j++) begin
                    if (qpb_baddr(s.wb_base[b], j) == ra) begin
                        w = qpb_merge(w, s.wb_d[b][j], s.wb_en[b][j]);
                    end
                end
            end
        end
        qpb_fetch = w;
    endfunction : qpb_fetch

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic is_k;
    logic [3:0] lat;
    logic launch;
    qpb_addr_t ra;
    logic placed;
    logic cb;

    always_comb begin
        nxt_st = st_ff;
        is_k = (link.k_phase == QPB_PH_K);
        launch = 1'b0;
        ra = '0;
        placed = 1'b0;
        cb = st_ff.wsel;

        nxt_st.doff_sync = {st_ff.doff_sync[0], link.doff_n};
        lat = st_ff.doff_sync[1] ? `QPB_LAT_DLL : `QPB_LAT_BYP;

        // echo toggles every edge, data or not
        nxt_st.echo = is_k;

        // read bursts in flight, select ignored here
        nxt_st.vld = 1'b0;
        for (int r = 0; r < NRS; r++) begin
            if (st_ff.rs_v[r]) begin
                nxt_st.rs_cnt[r] = st_ff.rs_cnt[r] + 4'h1;
                for (int i = 0; i < `QPB_BURST; i++) begin
                    if (st_ff.rs_cnt[r] == lat + 4'(i)) begin
                        launch = 1'b1;
                        ra = qpb_baddr(st_ff.rs_base[r], i);
                    end
                end
                if (st_ff.rs_cnt[r] >= lat - 4'h1 && st_ff.rs_cnt[r] <= lat + 4'h2) begin
                    nxt_st.vld = 1'b1;
                end
                if (st_ff.rs_cnt[r] == lat + 4'(`QPB_BURST - 1)) begin
                    nxt_st.rs_v[r] = 1'b0;
                end
            end
        end
        if (launch) begin
            nxt_st.q = qpb_fetch(st_ff, ra);
        end

        // new read on true clock edge
        if (is_k && !link.rd_sel_n) begin
            for (int r = 0; r < NRS; r++) begin
                if (!placed && !nxt_st.rs_v[r]) begin
                    placed = 1'b1;
                    nxt_st.rs_v[r] = 1'b1;
                    nxt_st.rs_cnt[r] = 4'h1;
                    nxt_st.rs_base[r] = link.rd_addr;
                end
            end
        end

        // write buffers: capture beats, then commit
        for (int b = 0; b < 2; b++) begin
            if (st_ff.wb_v[b]) begin
                nxt_st.wb_cnt[b] = st_ff.wb_cnt[b] + 4'h1;
                for (int j = 0; j < `QPB_BURST; j++) begin
                    if (st_ff.wb_cnt[b] == `QPB_WR_FIRST + 4'(j)) begin
                        nxt_st.wb_d[b][j] = link.wr_data;
                        nxt_st.wb_en[b][j] = ~link.byte_write_mask_n;
                    end
                end
                if (st_ff.wb_cnt[b] == `QPB_WR_COMMIT) begin
                    for (int j = 0; j < `QPB_BURST; j++) begin
                        ra = qpb_baddr(st_ff.wb_base[b], j);
                        nxt_st.mem[ra[ARR_AW-1:0]] = qpb_merge(nxt_st.mem[ra[ARR_AW-1:0]],
                                                               st_ff.wb_d[b][j], st_ff.wb_en[b][j]);
                    end
                    nxt_st.wb_v[b] = 1'b0;
                end
            end
        end

        // new write; high select leaves everything alone
        if (is_k && !link.wr_sel_n) begin
            nxt_st.wb_v[cb] = 1'b1;
            nxt_st.wb_cnt[cb] = 4'h1;
            nxt_st.wb_base[cb] = link.wr_addr;
            nxt_st.wb_en[cb] = '0;
            nxt_st.wsel = ~st_ff.wsel;
        end
    end

    // ----------------------------------------------------------------
    // state register, link clock
    // ----------------------------------------------------------------
    always_ff @(posedge link.k2x or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign link.rd_data = st_ff.q;
    assign link.echo_timing_out = st_ff.echo;
    assign link.echo_timing_out_inv = ~st_ff.echo;
    assign link.output_valid_flag = st_ff.vld;

endmodule : qpb_dev

// *** core/qpb_ctl.sv ***
`timescale 1ns/1ps
`include "qpb_cfg.svh"

module qpb_ctl #(
    parameter int DATA_W = `QPB_DATA_W,
    parameter int ADDR_W = `QPB_ADDR_W,
    parameter int NL = DATA_W / `QPB_LANE_W
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // mode
    input wire logic dll_off_in,
    // read request
    input wire logic rd_req_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic rd_ready_out,
    output logic [`QPB_BURST*DATA_W-1:0] rd_data_out,
    output logic rd_valid_out,
    // write request
    input wire logic wr_req_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [`QPB_BURST*DATA_W-1:0] wr_data_in,
    input wire logic [`QPB_BURST*NL-1:0] wr_mask_n_in,
    output logic wr_ready_out,
    // link
    qpb_if.ctl link
);
    import qpb_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic k2x;
        qpb_phase_t kph;
        logic rd_sel_n;
        logic wr_sel_n;
        logic [ADDR_W-1:0] rd_addr;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] d;
        logic [NL-1:0] m_n;
        logic doff_n;
        logic [1:0] rd_gap;
        logic [1:0] wr_gap;
        logic wt_sel;
        logic [1:0] wt_v;
        logic [1:0][3:0] wt_cnt;
        logic [1:0][`QPB_BURST*DATA_W-1:0] wt_d;
        logic [1:0][`QPB_BURST*NL-1:0] wt_m;
        logic flag_prev;
        logic [1:0] cap_cnt;
        logic [`QPB_BURST*DATA_W-1:0] cap;
        logic rvalid;
    } qpb_ctl_st_t;

    qpb_ctl_st_t st_ff;
    qpb_ctl_st_t nxt_st;
    logic launch;
    logic nxt_k;
    logic [3:0] c;

    // ----------------------------------------------------------------
    // next state; link outputs other than k2x change only on the edge where k2x falls
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        launch = st_ff.k2x;
        nxt_k = (st_ff.kph == QPB_PH_KN);
        c = 4'h0;
        nxt_st.k2x = ~st_ff.k2x;
        nxt_st.rvalid = 1'b0;
        rd_ready_out = launch && nxt_k && (st_ff.rd_gap == 2'h0);
        wr_ready_out = launch && nxt_k && (st_ff.wr_gap == 2'h0);
        if (launch) begin
            nxt_st.kph = nxt_k ? QPB_PH_K : QPB_PH_KN;
            nxt_st.rd_sel_n = 1'b1;
            nxt_st.wr_sel_n = 1'b1;
            nxt_st.doff_n = ~dll_off_in;
            if (st_ff.rd_gap != 2'h0) begin
                nxt_st.rd_gap = st_ff.rd_gap - 2'h1;
            end
            if (st_ff.wr_gap != 2'h0) begin
                nxt_st.wr_gap = st_ff.wr_gap - 2'h1;
            end
            if (rd_req_in && rd_ready_out) begin
                nxt_st.rd_sel_n = 1'b0;
                nxt_st.rd_addr = rd_addr_in;
                nxt_st.rd_gap = `QPB_CMD_GAP;
            end
            for (int b = 0; b < 2; b++) begin
                if (st_ff.wt_v[b]) begin
                    c = st_ff.wt_cnt[b] + 4'h1;
                    nxt_st.wt_cnt[b] = c;
                    for (int j = 0; j < `QPB_BURST; j++) begin
                        if (c == `QPB_WR_FIRST + 4'(j)) begin
                            nxt_st.d = st_ff.wt_d[b][j*DATA_W +: DATA_W];
                            nxt_st.m_n = st_ff.wt_m[b][j*NL +: NL];
                        end
                    end
                    if (c == `QPB_WR_LAST) begin
                        nxt_st.wt_v[b] = 1'b0;
                    end
                end
            end
            if (wr_req_in && wr_ready_out) begin
                nxt_st.wr_sel_n = 1'b0;
                nxt_st.wr_addr = wr_addr_in;
                nxt_st.wr_gap = `QPB_CMD_GAP;
                nxt_st.wt_v[st_ff.wt_sel] = 1'b1;
                nxt_st.wt_cnt[st_ff.wt_sel] = 4'h0;
                nxt_st.wt_d[st_ff.wt_sel] = wr_data_in;
                nxt_st.wt_m[st_ff.wt_sel] = wr_mask_n_in;
                nxt_st.wt_sel = ~st_ff.wt_sel;
            end
            // read beats follow the valid flag by half a cycle
            nxt_st.flag_prev = link.output_valid_flag;
            if (st_ff.flag_prev) begin
                nxt_st.cap[st_ff.cap_cnt*DATA_W +: DATA_W] = link.rd_data;
                nxt_st.cap_cnt = st_ff.cap_cnt + 2'h1;
                if (st_ff.cap_cnt == `QPB_CAP_LAST) begin
                    nxt_st.rvalid = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '{kph: QPB_PH_KN, rd_sel_n: 1'b1, wr_sel_n: 1'b1, m_n: '1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rd_data_out = st_ff.cap;
    assign rd_valid_out = st_ff.rvalid;
    assign link.k2x = st_ff.k2x;
    assign link.k_phase = st_ff.kph;
    assign link.rd_sel_n = st_ff.rd_sel_n;
    assign link.wr_sel_n = st_ff.wr_sel_n;
    assign link.rd_addr = st_ff.rd_addr;
    assign link.wr_addr = st_ff.wr_addr;
    assign link.wr_data = st_ff.d;
    assign link.byte_write_mask_n = st_ff.m_n;
    assign link.doff_n = st_ff.doff_n;

endmodule : qpb_ctl

// *** sim/qpb_asserts.sv ***
`timescale 1ns/1ps

module qpb_asserts
    import qpb_pkg::*;
(
    // link
    input wire logic k2x,
    input wire qpb_pkg::qpb_phase_t k_phase,
    input wire logic rd_sel_n,
    input wire logic wr_sel_n,
    input wire logic doff_n,
    input wire logic echo_timing_out,
    input wire logic echo_timing_out_inv,
    input wire logic output_valid_flag,
    // reset
    input wire logic rst_b_in
);
    logic rd_cmd;
    logic wr_cmd;
    assign rd_cmd = !rd_sel_n && (k_phase == QPB_PH_K);
    assign wr_cmd = !wr_sel_n && (k_phase == QPB_PH_K);

    default clocking cb @(posedge k2x);
    endclocking
    default disable iff (!rst_b_in);

    // ----
    // checks
    // ----
    a_echo_pair: assert property (echo_timing_out_inv == !echo_timing_out)
        else $error("echo pair not complementary");
    a_echo_phase: assert property (##1 echo_timing_out == ($past(k_phase) == QPB_PH_K))
        else $error("echo clock off phase");
    a_rd_lat_dll: assert property (rd_cmd && doff_n && $past(doff_n, 3) |-> ##5 output_valid_flag [*4])
        else $error("read window wrong with dll on");
    a_rd_lat_byp: assert property (rd_cmd && !doff_n && !$past(doff_n, 3) |-> ##2 output_valid_flag [*4])
        else $error("read window wrong in bypass");
    a_flag_cause: assert property ($rose(output_valid_flag) |-> $past(rd_cmd, 5) || $past(rd_cmd, 2))
        else $error("valid flag without read");
    a_flag_len: assert property ($fell(output_valid_flag) |-> $past(output_valid_flag, 4))
        else $error("valid window shorter than burst");
    a_rd_spacing: assert property (rd_cmd |=> !rd_cmd [*3])
        else $error("reads too close");
    a_wr_spacing: assert property (wr_cmd |=> !wr_cmd [*3])
        else $error("writes too close");
    a_wr_beats: assert property (wr_cmd |-> ##2 k_phase == QPB_PH_K ##1 k_phase == QPB_PH_KN
        ##1 k_phase == QPB_PH_K ##1 k_phase == QPB_PH_KN)
        else $error("write beat edges out of order");

    c_both: cover property (rd_cmd && wr_cmd);
    c_rd_b2b: cover property (rd_cmd ##4 rd_cmd);
    c_byp: cover property (rd_cmd && !doff_n);
endmodule : qpb_asserts

// *** sim/tb.sv ***
`timescale 1ns/1ps

module tb;
    import qpb_pkg::*;
    localparam int DW = 36;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b1;
    logic dll_off_in = 1'b0;
    logic rd_req_in = 1'b0;
    logic wr_req_in = 1'b0;
    logic [18:0] rd_addr_in = '0;
    logic [18:0] wr_addr_in = '0;
    logic [143:0] wr_data_in = '0;
    logic [15:0] wr_mask_n_in = '1;
    logic rd_ready_out;
    logic wr_ready_out;
    logic rd_valid_out;
    logic [143:0] rd_data_out;
    logic [35:0] mem [256];
    logic [143:0] exp_q [$];
    int due_q [$];
    int cyc = 0;
    int fail_count = 0;
    int total_checks = 0;
    logic [15:0] seed = 16'h003e;
    logic [7:0] a;

    // ----
    // structure
    // ----
    qpb_if lk ();
    qpb_ctl i_qpb_ctl (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .dll_off_in(dll_off_in),
        .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in), .rd_ready_out(rd_ready_out),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .wr_req_in(wr_req_in),
        .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in), .wr_mask_n_in(wr_mask_n_in),
        .wr_ready_out(wr_ready_out), .link(lk));
    qpb_dev i_qpb_dev (.link(lk), .rst_b_in(rst_b_in));
    qpb_asserts i_qpb_asserts (.k2x(lk.k2x), .k_phase(lk.k_phase), .rd_sel_n(lk.rd_sel_n),
        .wr_sel_n(lk.wr_sel_n), .doff_n(lk.doff_n), .echo_timing_out(lk.echo_timing_out),
        .echo_timing_out_inv(lk.echo_timing_out_inv), .output_valid_flag(lk.output_valid_flag),
        .rst_b_in(rst_b_in));

    initial begin
        forever #5 mclk_in = ~mclk_in;
    end

    // ----
    // helpers
    // ----
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd

    task automatic check(input logic [143:0] seen, input logic [143:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // one assignment per input, so no signal is written twice in a step
    task automatic load_wr(input logic [7:0] set, input logic [7:0] pick);
        logic [143:0] d;
        for (int k = 0; k < 9; k++) begin
            d[k*16+:16] = rnd();
        end
        wr_addr_in <= {11'h000, (pick & 8'h7b) | set};
        wr_mask_n_in <= rnd();
        wr_data_in <= d;
    endtask : load_wr

    // model update per beat and lane, masked lanes kept
    task automatic note_wr();
        for (int j = 0; j < 4; j++) begin
            for (int l = 0; l < 4; l++) begin
                if (!wr_mask_n_in[j*4+l]) begin
                    mem[8'(wr_addr_in + j)][l*9+:9] = wr_data_in[j*DW+l*9+:9];
                end
            end
        end
    endtask : note_wr

    task automatic note_rd();
        logic [143:0] e;
        for (int j = 0; j < 4; j++) begin
            e[j*DW+:DW] = mem[8'(rd_addr_in + j)];
        end
        exp_q.push_back(e);
        due_q.push_back(cyc + (dll_off_in ? 13 : 19));
    endtask : note_rd

    // n takes per direction, requests held back to back
    task automatic issue(input logic r, input logic w, input int n, input int settle);
        int nr;
        int nw;
        nr = r ? n : 0;
        nw = w ? n : 0;
        if (r) rd_req_in <= 1'b1;
        if (w) wr_req_in <= 1'b1;
        while (nr > 0 || nw > 0) begin
            @(posedge mclk_in);
            if (rd_req_in && rd_ready_out === 1'b1) begin
                note_rd();
                nr--;
                rd_addr_in <= {11'h000, 8'(rnd()) & 8'h7b};
                if (nr == 0) rd_req_in <= 1'b0;
            end
            if (wr_req_in && wr_ready_out === 1'b1) begin
                note_wr();
                nw--;
                load_wr(8'h80, 8'(rnd()));
                if (nw == 0) wr_req_in <= 1'b0;
            end
        end
        repeat (settle) @(posedge mclk_in);
    endtask : issue

    // ----
    // monitor and sequence
    // ----
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
        if (rd_valid_out === 1'b1) begin
            check(rd_data_out, exp_q.pop_front());
            check(144'(cyc - due_q.pop_front()), 144'h0);
        end
    end

    initial begin
        rst_b_in <= 1'b0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = '0;
        end
        repeat (16) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            repeat (40) @(posedge mclk_in);
            dll_off_in <= m[0];
            repeat (40) @(posedge mclk_in);
            for (int i = 0; i < 18; i++) begin
                a = 8'(rnd()) & 8'h7b;
                case (i % 3)
                    // read one cycle behind a write to the same words: buffer path for beats 0-2 with dll off, committed array with dll on
                    0: begin
                        load_wr(8'h00, a);
                        rd_addr_in <= {11'h000, a};
                        issue(1'b0, 1'b1, 1, 0);
                        issue(1'b1, 1'b0, 1, 8);
                    end
                    1: begin
                        rd_addr_in <= {11'h000, a | 8'h80};
                        load_wr(8'h00, 8'(rnd()));
                        issue(1'b1, 1'b1, 1, 8);
                    end
                    default: begin
                        rd_addr_in <= {11'h000, a};
                        load_wr(8'h80, 8'(rnd()));
                        issue(1'b1, 1'b1, 4, 8);
                    end
                endcase
                $display("test %0d done", m * 18 + i);
            end
        end
        repeat (60) @(posedge mclk_in);
        check(144'(exp_q.size()), 144'h0);
        complete_run();
    end
endmodule : tb
